// File: rtl/rsse_pkg.sv
package rsse_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INSTR = 8'h04;
    localparam logic [7:0] REG_WREG = 8'h08;
    localparam logic [7:0] REG_BANKSEL = 8'h0c;
    localparam logic [7:0] REG_FSR2 = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_WDT = 8'h18;
    localparam logic [7:0] REG_MADDR = 8'h1c;
    localparam logic [7:0] REG_MDATA = 8'h20;
    localparam logic [7:0] REG_EADDR = 8'h24;

    // Control register fields.
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;

    // Status register fields.
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_NEG_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_TO_BIT = 3;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_SLEEP_BIT = 5;
    localparam int ST_ILLEGAL_BIT = 6;

    // Watchdog register fields.
    localparam int WDT_POST_LSB = 8;

    // Opcode encodings.
    localparam logic [5:0] OPC_ROT = 6'h10;
    localparam logic [6:0] OPC_SET = 7'h34;
    localparam logic [15:0] OPC_SLEEP = 16'h0003;
    localparam int OPC_ROT_LSB = 10;
    localparam int OPC_SET_LSB = 9;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;

    // Addressing constants.
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] WDT_CLEAR = 8'h00;

    // Reset values.
    localparam logic RST_TO_N = 1'b1;
    localparam logic RST_PD_N = 1'b1;

    localparam int MEM_AW = 12;
    localparam int MEM_DEPTH = 4096;

    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROC = 2'b10,
        PH_WRITE = 2'b11
    } rsse_phase_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ROT = 2'b01,
        OP_SET = 2'b10,
        OP_SLEEP = 2'b11
    } rsse_op_t;

    typedef struct packed {
        logic ext_en;
        logic sleeping;
        logic busy;
        rsse_phase_t phase;
        rsse_op_t op;
        logic [15:0] instr;
        logic [7:0] wreg;
        logic [3:0] bank;
        logic [11:0] fsr2;
        logic zero;
        logic neg;
        logic to_n;
        logic pd_n;
        logic illegal;
        logic [7:0] wdt;
        logic [7:0] post;
        logic [11:0] maddr;
        logic [11:0] eaddr;
        logic [7:0] opnd;
        logic [7:0] result;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } rsse_state_t;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][7:0] cells;
    } rsse_mem_t;

endpackage : rsse_pkg

// File: rtl/rsse_data_mem.sv
`timescale 1ns/1ns
`default_nettype none
module rsse_data_mem
    import rsse_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // Write port.
    input wire logic we_in,
    input wire logic [MEM_AW-1:0] waddr_in,
    input wire logic [7:0] wdata_in,
    // Read ports.
    input wire logic [MEM_AW-1:0] core_raddr_in,
    output logic [7:0] core_rdata_out,
    input wire logic [MEM_AW-1:0] bus_raddr_in,
    output logic [7:0] bus_rdata_out
);

    rsse_mem_t mem_r;
    rsse_mem_t mem_nxt;

    always_comb begin
        mem_nxt = mem_r;
        if (we_in) begin
            mem_nxt.cells[waddr_in] = wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mem_r <= '0;
        end else if (ce_in) begin
            mem_r <= mem_nxt;
        end
    end

    assign core_rdata_out = mem_r.cells[core_raddr_in];
    assign bus_rdata_out = mem_r.cells[bus_raddr_in];

endmodule : rsse_data_mem
`default_nettype wire

// File: rtl/rsse_exec.sv
// Summary of operation
// RULE1 - Rotate right, bit0 into bit7, flags N Z.
// RULE2 - Destination bit 0 to W, 1 to file.
// RULE3 - Access bit 0 selects access bank only. Here, in extended mode, operands up to 95 are indexed through FSR2 instead.
// RULE4 - Access bit 1 uses bank register plus operand.
// RULE5 - Extended mode, operand up to 95 is indexed.
// RULE6 - Set file writes all ones, flags unchanged.
// RULE7 - Sleep clears watchdog, sets timeout, clears powerdown.
// RULE8 - Sleep halts oscillator, second phase does nothing.
// RULE9 - One word, one cycle of four phases.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rsse_exec
    import rsse_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Core status.
    output logic osc_halt_out,
    output logic busy_out
);

    rsse_state_t s_r;
    rsse_state_t s_nxt;

    logic [7:0] core_rdata;
    logic [7:0] bus_rdata;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic [7:0] mem_wdata;

    function automatic logic [MEM_AW-1:0] rsse_eff_addr(input logic [7:0] f, input logic a, input logic ext,
                                                       input logic [3:0] bank, input logic [11:0] fsr2);
        logic [MEM_AW-1:0] addr;
        addr = '0;
        if (a) begin
            addr = {bank, f}; // RULE4
        end else if (ext && (f <= IDX_LIMIT)) begin
            addr = fsr2 + {4'h0, f}; // RULE5
        end else if (f <= IDX_LIMIT) begin
            addr = {ACC_LOW_BANK, f}; // RULE3
        end else begin
            addr = {ACC_HIGH_BANK, f}; // RULE3
        end
        return addr;
    endfunction : rsse_eff_addr

    function automatic rsse_op_t rsse_decode(input logic [15:0] instr);
        rsse_op_t op;
        op = OP_NONE;
        if (instr[15:OPC_ROT_LSB] == OPC_ROT) begin
            op = OP_ROT;
        end else if (instr[15:OPC_SET_LSB] == OPC_SET) begin
            op = OP_SET;
        end else if (instr == OPC_SLEEP) begin
            op = OP_SLEEP;
        end
        return op;
    endfunction : rsse_decode

    function automatic logic rsse_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            REG_CTRL, REG_INSTR, REG_WREG, REG_BANKSEL, REG_FSR2, REG_STATUS, REG_WDT, REG_MADDR, REG_MDATA,
            REG_EADDR: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : rsse_mapped

    rsse_data_mem u_mem (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .core_raddr_in(s_r.eaddr),
        .core_rdata_out(core_rdata),
        .bus_raddr_in(s_r.maddr),
        .bus_rdata_out(bus_rdata)
    );

    always_comb begin
        logic setup;
        logic access;
        logic refused;
        logic [31:0] rd;
        logic [7:0] res;
        setup = 1'b0;
        access = 1'b0;
        refused = 1'b0;
        rd = '0;
        res = '0;
        s_nxt = s_r;
        mem_we = 1'b0;
        mem_waddr = s_r.eaddr;
        mem_wdata = s_r.result;

        // Instruction sequencer, one phase per enabled clock.
        if (s_r.busy) begin
            case (s_r.phase)
                PH_DECODE: begin
                    s_nxt.op = rsse_decode(s_r.instr);
                    s_nxt.illegal = (rsse_decode(s_r.instr) == OP_NONE);
                    s_nxt.eaddr = rsse_eff_addr(s_r.instr[7:0], s_r.instr[ACCESS_BIT], s_r.ext_en, s_r.bank,
                                                s_r.fsr2);
                    s_nxt.phase = PH_READ; // RULE9
                end
                PH_READ: begin
                    if (s_r.op != OP_SLEEP) begin
                        s_nxt.opnd = core_rdata; // RULE8
                    end
                    s_nxt.phase = PH_PROC; // RULE9
                end
                PH_PROC: begin
                    case (s_r.op)
                        OP_ROT: begin
                            res = {s_r.opnd[0], s_r.opnd[7:1]}; // RULE1
                            s_nxt.result = res;
                            s_nxt.zero = (res == 8'h00); // RULE1
                            s_nxt.neg = res[7]; // RULE1
                        end
                        OP_SET: begin
                            s_nxt.result = ALL_ONES; // RULE6
                        end
                        OP_SLEEP: begin
                            s_nxt.wdt = WDT_CLEAR; // RULE7
                            s_nxt.post = WDT_CLEAR; // RULE7
                            s_nxt.to_n = 1'b1; // RULE7
                            s_nxt.pd_n = 1'b0; // RULE7
                        end
                        default: begin
                            s_nxt.result = s_r.result;
                        end
                    endcase
                    s_nxt.phase = PH_WRITE; // RULE9
                end
                PH_WRITE: begin
                    case (s_r.op)
                        OP_ROT: begin
                            if (s_r.instr[DEST_BIT]) begin
                                mem_we = 1'b1; // RULE2
                            end else begin
                                s_nxt.wreg = s_r.result; // RULE2
                            end
                        end
                        OP_SET: begin
                            mem_we = 1'b1; // RULE6
                        end
                        OP_SLEEP: begin
                            s_nxt.sleeping = 1'b1; // RULE8
                        end
                        default: begin
                            mem_we = 1'b0;
                        end
                    endcase
                    s_nxt.busy = 1'b0; // RULE9
                    s_nxt.phase = PH_DECODE;
                end
                default: begin
                    s_nxt.phase = PH_DECODE;
                end
            endcase
        end

        // APB slave: data prepared in setup, answered in the first access cycle.
        setup = psel_in && !penable_in;
        access = psel_in && penable_in && s_r.pready;
        s_nxt.pready = 1'b0;
        if (setup) begin
            case (paddr_in)
                REG_CTRL: begin
                    rd[CTRL_EXT_BIT] = s_r.ext_en;
                end
                REG_INSTR: begin
                    rd[15:0] = s_r.instr;
                end
                REG_WREG: begin
                    rd[7:0] = s_r.wreg;
                end
                REG_BANKSEL: begin
                    rd[3:0] = s_r.bank;
                end
                REG_FSR2: begin
                    rd[11:0] = s_r.fsr2;
                end
                REG_STATUS: begin
                    rd[ST_ZERO_BIT] = s_r.zero;
                    rd[ST_NEG_BIT] = s_r.neg;
                    rd[ST_PD_BIT] = s_r.pd_n;
                    rd[ST_TO_BIT] = s_r.to_n;
                    rd[ST_BUSY_BIT] = s_r.busy;
                    rd[ST_SLEEP_BIT] = s_r.sleeping;
                    rd[ST_ILLEGAL_BIT] = s_r.illegal;
                end
                REG_WDT: begin
                    rd[15:0] = {s_r.post, s_r.wdt};
                end
                REG_MADDR: begin
                    rd[11:0] = s_r.maddr;
                end
                REG_MDATA: begin
                    rd[7:0] = bus_rdata;
                end
                REG_EADDR: begin
                    rd[11:0] = s_r.eaddr;
                end
                default: begin
                    rd = '0;
                end
            endcase
            refused = pwrite_in && (paddr_in != REG_CTRL) && (s_r.busy || (paddr_in == REG_INSTR && s_r.sleeping));
            s_nxt.pready = 1'b1;
            s_nxt.prdata = rd;
            s_nxt.pslverr = !rsse_mapped(paddr_in) || refused;
        end

        if (access && pwrite_in && !s_r.pslverr) begin
            case (paddr_in)
                REG_CTRL: begin
                    s_nxt.ext_en = pwdata_in[CTRL_EXT_BIT];
                    // A sleep that completes in this very cycle wins over the wake request.
                    if (pwdata_in[CTRL_WAKE_BIT]
                        && !(s_r.busy && s_r.phase == PH_WRITE && s_r.op == OP_SLEEP)) begin // RULE8
                        s_nxt.sleeping = 1'b0;
                    end
                end
                REG_INSTR: begin
                    s_nxt.instr = pwdata_in[15:0];
                    s_nxt.busy = 1'b1;
                    s_nxt.phase = PH_DECODE;
                end
                REG_WREG: begin
                    s_nxt.wreg = pwdata_in[7:0];
                end
                REG_BANKSEL: begin
                    s_nxt.bank = pwdata_in[3:0];
                end
                REG_FSR2: begin
                    s_nxt.fsr2 = pwdata_in[11:0];
                end
                REG_STATUS: begin
                    s_nxt.zero = pwdata_in[ST_ZERO_BIT];
                    s_nxt.neg = pwdata_in[ST_NEG_BIT];
                    s_nxt.pd_n = pwdata_in[ST_PD_BIT];
                    s_nxt.to_n = pwdata_in[ST_TO_BIT];
                end
                REG_WDT: begin
                    s_nxt.wdt = pwdata_in[7:0];
                    s_nxt.post = pwdata_in[WDT_POST_LSB+7:WDT_POST_LSB];
                end
                REG_MADDR: begin
                    s_nxt.maddr = pwdata_in[11:0];
                end
                REG_MDATA: begin
                    mem_we = 1'b1;
                    mem_waddr = s_r.maddr;
                    mem_wdata = pwdata_in[7:0];
                end
                default: begin
                    mem_we = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_r <= '0;
            s_r.to_n <= RST_TO_N;
            s_r.pd_n <= RST_PD_N;
            s_r.phase <= PH_DECODE;
            s_r.op <= OP_NONE;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign osc_halt_out = s_r.sleeping;
    assign busy_out = s_r.busy;

endmodule : rsse_exec
`default_nettype wire

// File: tb/rsse_exec_props.sv
`timescale 1ns/1ns
`default_nettype none
module rsse_exec_props
    import rsse_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic osc_halt_out,
    input wire logic busy_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    wire logic setup = psel_in && !penable_in && ce_in;
    wire logic done = psel_in && penable_in && pready_out && ce_in && pwrite_in;
    wire logic instr_wr = done && paddr_in == REG_INSTR && !pslverr_out;
    wire logic wake_wr = done && paddr_in == REG_CTRL && pwdata_in[CTRL_WAKE_BIT];
    a_answer_next: assert property (setup |=> pready_out)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready_out && ce_in |=> !pready_out)
        else $error("ready held too long");
    a_busy_four: assert property ($rose(busy_out) |-> busy_out [*4] ##1 !busy_out)
        else $error("instruction not four phases");
    a_instr_starts: assert property (instr_wr |=> busy_out)
        else $error("accepted instruction did not start");
    a_no_spurious: assert property ($rose(busy_out) |-> $past(instr_wr))
        else $error("busy without instruction");
    a_halt_at_end: assert property ($rose(osc_halt_out) |-> $fell(busy_out))
        else $error("halt not at end of sleep");
    a_halt_holds: assert property (osc_halt_out && !wake_wr |=> osc_halt_out)
        else $error("halt dropped without wake");
    a_asleep_refuse: assert property (setup && pwrite_in && paddr_in == REG_INSTR && osc_halt_out
        |=> pslverr_out)
        else $error("instruction taken while asleep");
    a_busy_refuse: assert property (setup && pwrite_in && paddr_in != REG_CTRL && busy_out
        |=> pslverr_out)
        else $error("write taken while busy");
    c_instr: cover property (instr_wr);
    c_sleep: cover property ($rose(osc_halt_out));
    c_busy_wr: cover property (setup && pwrite_in && busy_out);
endmodule : rsse_exec_props
bind rsse_exec rsse_exec_props i_props (.clock_in, .arst_n_in, .ce_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .osc_halt_out, .busy_out);
`default_nettype wire

// File: tb/rsse_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("unexpected %s exp %h got %h", n, e, g); \
    end \
end
module rsse_exec_tb
    import rsse_pkg::*;
;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, osc_halt_out, busy_out;
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] nb;
    rsse_exec i_dut (.clock_in, .arst_n_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .osc_halt_out, .busy_out);
    always #10 clock_in = ~clock_in;
    function automatic logic [7:0] rot(logic [7:0] v);
        return {v[0], v[7:1]};
    endfunction : rot
    function automatic logic [11:0] eff(logic a, logic [7:0] f, logic [3:0] b, logic [11:0] s, logic x);
        if (a) return {b, f};
        if (f <= IDX_LIMIT) return x ? s + {4'h0, f} : {4'h0, f};
        return {4'hf, f};
    endfunction : eff
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask : rdchk
    task automatic idle();
        nb = 8'h00;
        @(posedge clock_in);
        while (busy_out !== 1'b0 && nb < 8'h14) begin
            nb++;
            @(posedge clock_in);
        end
    endtask : idle
    task automatic run(input logic [15:0] ins);
        apb(1'b1, REG_INSTR, {16'h0, ins});
        `CHK("instr err", 1'b0, er)
        idle();
        `CHK("busy cycles", 8'h04, nb)
    endtask : run
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        n_errors++;
        $display("unexpected timeout");
        end_of_test();
    end
    initial begin
        logic [7:0] f, w, m, res;
        logic [3:0] b;
        logic [11:0] fs, ea;
        logic a, d, x, ro;
        logic [1:0] fl;
        void'($urandom(34));
        repeat (2) @(posedge clock_in);
        arst_n_in <= 1'b1;
        rdchk("status reset", REG_STATUS, 32'hc);
        apb(1'b0, 8'h2a, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        for (int i = 0; i < 16; i++) begin
            f = i == 0 ? 8'h5f : i == 1 ? 8'h60 : 8'($urandom);
            a = i < 2 ? 1'b0 : 1'($urandom);
            x = i < 2 ? 1'b1 : 1'($urandom);
            d = 1'($urandom);
            ro = (i % 3) != 2;
            w = 8'($urandom);
            m = i == 3 ? 8'h01 : i == 4 ? 8'h00 : 8'($urandom);
            b = 4'($urandom);
            fs = 12'($urandom);
            fl = 2'($urandom);
            ea = eff(a, f, b, fs, x);
            apb(1'b1, REG_CTRL, {31'h0, x});
            apb(1'b1, REG_WREG, {24'h0, w});
            apb(1'b1, REG_BANKSEL, {28'h0, b});
            apb(1'b1, REG_FSR2, {20'h0, fs});
            apb(1'b1, REG_MADDR, {20'h0, ea});
            apb(1'b1, REG_MDATA, {24'h0, m});
            apb(1'b1, REG_STATUS, {28'h0, 2'b11, fl});
            run(ro ? {OPC_ROT, d, a, f} : {OPC_SET, a, f});
            res = ro ? rot(m) : ALL_ONES;
            rdchk("eaddr", REG_EADDR, {20'h0, ea});
            rdchk("file", REG_MDATA, {24'h0, (ro && !d) ? m : res});
            rdchk("wreg", REG_WREG, {24'h0, (ro && !d) ? res : w});
            rdchk("flags", REG_STATUS, {28'h0, 2'b11, ro ? {res[7], res == 8'h0} : fl});
        end
        apb(1'b1, REG_INSTR, {16'h0, OPC_SET, 9'h010});
        apb(1'b1, REG_WREG, 32'h5a);
        `CHK("busy write err", 1'b1, er)
        idle();
        rdchk("wreg kept", REG_WREG, {24'h0, (ro && !d) ? res : w});
        apb(1'b1, REG_WDT, 32'ha5c3);
        apb(1'b1, REG_STATUS, 32'h4);
        run(OPC_SLEEP);
        `CHK("halt", 1'b1, osc_halt_out)
        rdchk("sleep status", REG_STATUS, 32'h28);
        rdchk("watchdog", REG_WDT, 32'h0);
        apb(1'b1, REG_INSTR, {16'h0, OPC_SET, 9'h010});
        `CHK("asleep err", 1'b1, er)
        apb(1'b1, REG_CTRL, 32'h2);
        rdchk("awake status", REG_STATUS, 32'h08);
        `CHK("halt after wake", 1'b0, osc_halt_out)
        run(16'h0000);
        rdchk("unsupported status", REG_STATUS, 32'h48);
        end_of_test();
    end
endmodule : rsse_exec_tb
`default_nettype wire
